/* File: hdl/gear_pp_setpoint.sv */
// How it works
// - Motor increments equal reference increments times numerator over denominator.
// - Selection 0 uses free pair; 1..11 pick fixed counts; resets to 0.
// - A fixed selection gives one revolution per selected reference count.
// - Negative numerator reverses motor direction.
// - Numerator and denominator reset to one, unity ratio.
// - Free ratio takes effect on numerator write; denominator waits.
// - Direction setting 1 positive, 2 negative, 3 both; blocked motion suppressed.
// - Profile commands only act in fieldbus control mode.
// - Control bit 6 low means absolute target, high means relative.
// - Relative target adds to actual position or previous target by option.
// - Rising edge of control bit 4 starts or prepares a positioning.
// - Control bit 5 is sampled only at that rising edge.
// - With bit 5 low, values wait until current target is reached.
// - A later transfer replaces any waiting set.
// - With bit 5 high, new values apply immediately.
// - Status bit 10 set only on target reached, not on halt or error.
// - Status bit 12 marks acceptance, clears when next transfer possible.
// - Bit 14 shows completion at standstill; bit 13 shows an error.
// - Bit 15 shows a valid reference point.
// - Fixed ratios use 131072 motor increments per revolution.
`timescale 1ns/100ps
`default_nettype none
module gear_pp_setpoint (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Parameter channel
    input wire logic par_wr_i,
    input wire logic par_rd_i,
    input wire logic [15:0] par_addr_i,
    input wire logic [31:0] par_wdata_i,
    output logic par_ack_o,
    output logic [31:0] par_rdata_o,
    // Reference and motor increments
    input wire logic ref_valid_i,
    input wire logic signed [15:0] ref_inc_i,
    output logic mot_valid_o,
    output logic signed [31:0] mot_inc_o,
    // Drive state
    input wire logic fieldbus_mode_i,
    input wire logic homed_i,
    input wire logic halt_i,
    input wire logic fault_i,
    input wire logic standstill_i,
    input wire logic signed [31:0] axis_pos_i,
    input wire logic target_reached_i,
    // Profile setpoint
    output logic sp_load_o,
    output logic signed [31:0] sp_pos_o,
    output logic [31:0] sp_speed_o,
    output logic [31:0] sp_acc_o,
    output logic [31:0] sp_dec_o,
    output logic [15:0] status_word_o
);
    import gear_pp_pkg::*;

    // Parameter registers
    logic signed [31:0] num_q, num_d;
    logic [31:0] den_pend_q, den_pend_d;
    logic [31:0] den_act_q, den_act_d;
    logic [1:0] dir_q, dir_d;
    logic [3:0] sel_q, sel_d;
    logic [15:0] ctl_q, ctl_d;
    logic signed [31:0] tpos_q, tpos_d;
    logic [31:0] tspd_q, tspd_d;
    logic [31:0] tacc_q, tacc_d;
    logic [31:0] tdec_q, tdec_d;
    logic [1:0] opt_q, opt_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;

    // Profile handshake state
    pp_state_t state_q, state_d;
    logic nsp_prev_q;
    logic load_q, load_d;
    logic signed [31:0] pos_q, pos_d;
    logic [31:0] spd_q, spd_d;
    logic [31:0] acc_q, acc_d;
    logic [31:0] dec_q, dec_d;
    logic signed [31:0] ppos_q, ppos_d;
    logic [31:0] pspd_q, pspd_d;
    logic [31:0] pacc_q, pacc_d;
    logic [31:0] pdec_q, pdec_d;
    logic reached_q, reached_d;
    logic spack_q, spack_d;
    logic err_q, end_q, refok_q;

    logic nsp_rise;
    logic accept;
    logic signed [31:0] new_tgt;
    logic signed [31:0] gear_num;
    logic [31:0] gear_den;
    logic [15:0] status;

    // Fixed selections drive one revolution per selected count
    always_comb begin
        if (sel_q == RST_GEAR_SEL) begin
            gear_num = num_q;
            gear_den = den_act_q;
        end else begin
            gear_num = $signed(MOTOR_RES);
            gear_den = ratio_count(sel_q);
        end
    end

    gear_scaler u_gear (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .ref_valid_i(ref_valid_i),
        .ref_inc_i(ref_inc_i),
        .num_i(gear_num),
        .den_i(gear_den),
        .dir_allow_i(dir_q),
        .mot_valid_o(mot_valid_o),
        .mot_inc_o(mot_inc_o)
    );

    assign status = {refok_q, end_q, err_q, spack_q, 1'b0, reached_q, 10'h000};

    // Parameter channel
    always_comb begin
        num_d = num_q;
        den_pend_d = den_pend_q;
        den_act_d = den_act_q;
        dir_d = dir_q;
        sel_d = sel_q;
        ctl_d = ctl_q;
        tpos_d = tpos_q;
        tspd_d = tspd_q;
        tacc_d = tacc_q;
        tdec_d = tdec_q;
        opt_d = opt_q;
        ack_d = par_wr_i | par_rd_i;
        rdata_d = '0;
        if (par_wr_i) begin
            case (par_addr_i)
                ADDR_GEAR_DEN: begin
                    // Zero would stall the divider; one is the least legal value
                    if (par_wdata_i != '0) begin
                        den_pend_d = par_wdata_i;
                    end
                end
                ADDR_GEAR_NUM: begin
                    num_d = $signed(par_wdata_i);
                    den_act_d = den_pend_q;
                end
                ADDR_GEAR_DIR: begin
                    if (par_wdata_i[1:0] != 2'h0 && par_wdata_i[31:2] == '0) begin
                        dir_d = par_wdata_i[1:0];
                    end
                end
                ADDR_GEAR_SEL: begin
                    if (par_wdata_i <= 32'(GEAR_SEL_MAX)) begin
                        sel_d = par_wdata_i[3:0];
                    end
                end
                ADDR_CTL_WORD: ctl_d = par_wdata_i[15:0];
                ADDR_TGT_POS: tpos_d = $signed(par_wdata_i);
                ADDR_TGT_SPD: tspd_d = par_wdata_i;
                ADDR_ACC: tacc_d = par_wdata_i;
                ADDR_DEC: tdec_d = par_wdata_i;
                ADDR_PP_OPT: opt_d = par_wdata_i[1:0];
                default: ;
            endcase
        end
        if (par_rd_i) begin
            case (par_addr_i)
                ADDR_GEAR_DEN: rdata_d = den_pend_q;
                ADDR_GEAR_NUM: rdata_d = num_q;
                ADDR_GEAR_DIR: rdata_d = {30'h0000_0000, dir_q};
                ADDR_GEAR_SEL: rdata_d = {28'h000_0000, sel_q};
                ADDR_CTL_WORD: rdata_d = {16'h0000, ctl_q};
                ADDR_STAT_WORD: rdata_d = {16'h0000, status};
                ADDR_TGT_POS: rdata_d = tpos_q;
                ADDR_TGT_SPD: rdata_d = tspd_q;
                ADDR_ACC: rdata_d = tacc_q;
                ADDR_DEC: rdata_d = tdec_q;
                ADDR_PP_OPT: rdata_d = {30'h0000_0000, opt_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            num_q <= RST_GEAR_NUM;
            den_pend_q <= RST_GEAR_DEN;
            den_act_q <= RST_GEAR_DEN;
            dir_q <= RST_GEAR_DIR;
            sel_q <= RST_GEAR_SEL;
            ctl_q <= RST_CTL_WORD;
            tpos_q <= '0;
            tspd_q <= '0;
            tacc_q <= '0;
            tdec_q <= '0;
            opt_q <= RST_PP_OPT;
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            num_q <= num_d;
            den_pend_q <= den_pend_d;
            den_act_q <= den_act_d;
            dir_q <= dir_d;
            sel_q <= sel_d;
            ctl_q <= ctl_d;
            tpos_q <= tpos_d;
            tspd_q <= tspd_d;
            tacc_q <= tacc_d;
            tdec_q <= tdec_d;
            opt_q <= opt_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Profile position handshake
    assign nsp_rise = ctl_q[CTL_NEW_SETPOINT] & ~nsp_prev_q;
    assign accept = nsp_rise & fieldbus_mode_i;

    always_comb begin
        if (ctl_q[CTL_RELATIVE]) begin
            new_tgt = tpos_q + ((opt_q == OPT_REL_ACTUAL) ? axis_pos_i : pos_q);
        end else begin
            new_tgt = tpos_q;
        end
    end

    always_comb begin
        state_d = state_q;
        load_d = 1'b0;
        pos_d = pos_q;
        spd_d = spd_q;
        acc_d = acc_q;
        dec_d = dec_q;
        ppos_d = ppos_q;
        pspd_d = pspd_q;
        pacc_d = pacc_q;
        pdec_d = pdec_q;
        reached_d = reached_q;
        spack_d = spack_q;
        if (halt_i || fault_i) begin
            // Aborted motion never counts as reached; a waiting set is dropped
            state_d = ST_IDLE;
            reached_d = 1'b0;
        end else if (target_reached_i) begin
            case (state_q)
                ST_MOVE: begin
                    state_d = ST_IDLE;
                    reached_d = 1'b1;
                end
                ST_MOVE_PEND: begin
                    state_d = ST_MOVE;
                    load_d = 1'b1;
                    pos_d = ppos_q;
                    spd_d = pspd_q;
                    acc_d = pacc_q;
                    dec_d = pdec_q;
                end
                default: ;
            endcase
        end
        // Next transfer possible once bit 4 is back low and no set waits
        if (!ctl_q[CTL_NEW_SETPOINT] && state_d != ST_MOVE_PEND) begin
            spack_d = 1'b0;
        end
        if (accept) begin
            spack_d = 1'b1;
            if (ctl_q[CTL_CHANGE_NOW] || state_d == ST_IDLE) begin
                state_d = ST_MOVE;
                load_d = 1'b1;
                reached_d = 1'b0;
                pos_d = new_tgt;
                spd_d = tspd_q;
                acc_d = tacc_q;
                dec_d = tdec_q;
            end else begin
                state_d = ST_MOVE_PEND;
                ppos_d = new_tgt;
                pspd_d = tspd_q;
                pacc_d = tacc_q;
                pdec_d = tdec_q;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            nsp_prev_q <= 1'b0;
            load_q <= 1'b0;
            pos_q <= '0;
            spd_q <= '0;
            acc_q <= '0;
            dec_q <= '0;
            ppos_q <= '0;
            pspd_q <= '0;
            pacc_q <= '0;
            pdec_q <= '0;
            reached_q <= 1'b0;
            spack_q <= 1'b0;
            err_q <= 1'b0;
            end_q <= 1'b0;
            refok_q <= 1'b0;
        end else begin
            state_q <= state_d;
            nsp_prev_q <= ctl_q[CTL_NEW_SETPOINT];
            load_q <= load_d;
            pos_q <= pos_d;
            spd_q <= spd_d;
            acc_q <= acc_d;
            dec_q <= dec_d;
            ppos_q <= ppos_d;
            pspd_q <= pspd_d;
            pacc_q <= pacc_d;
            pdec_q <= pdec_d;
            reached_q <= reached_d;
            spack_q <= spack_d;
            err_q <= fault_i;
            end_q <= (state_d == ST_IDLE) && standstill_i;
            refok_q <= homed_i;
        end
    end

    assign par_ack_o = ack_q;
    assign par_rdata_o = rdata_q;
    assign sp_load_o = load_q;
    assign sp_pos_o = pos_q;
    assign sp_speed_o = spd_q;
    assign sp_acc_o = acc_q;
    assign sp_dec_o = dec_q;
    assign status_word_o = status;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    chk_den_waits: assert property (
        par_wr_i && par_addr_i == ADDR_GEAR_DEN |=> $stable(den_act_q))
        else $error("denominator applied without numerator write");
    chk_num_applies: assert property (
        par_wr_i && par_addr_i == ADDR_GEAR_NUM |=> den_act_q == $past(den_pend_q))
        else $error("numerator write did not apply pending denominator");
    chk_local_ignored: assert property (
        nsp_rise && !fieldbus_mode_i && !halt_i && !fault_i && !target_reached_i
        |=> !sp_load_o && $stable(state_q))
        else $error("command acted under local control");
    chk_abs_immediate: assert property (
        accept && ctl_q[CTL_CHANGE_NOW] && !ctl_q[CTL_RELATIVE]
        |=> sp_load_o && sp_pos_o == $past(tpos_q))
        else $error("absolute immediate target not loaded");
    chk_rel_target: assert property (
        accept && ctl_q[CTL_CHANGE_NOW] |=> sp_load_o && sp_pos_o == $past(new_tgt))
        else $error("immediate set not applied");
    chk_set_buffered: assert property (
        accept && !ctl_q[CTL_CHANGE_NOW] && state_q != ST_IDLE
        && !halt_i && !fault_i && !target_reached_i
        |=> !sp_load_o && state_q == ST_MOVE_PEND ##0 ppos_q == $past(new_tgt))
        else $error("buffered set not held");
    chk_reached_cause: assert property (
        $rose(reached_q) |-> $past(target_reached_i) && !$past(halt_i) && !$past(fault_i))
        else $error("reached set without target reached");
    chk_ack_raised: assert property (
        accept |=> spack_q ##1 (spack_q || !ctl_q[CTL_NEW_SETPOINT]))
        else $error("acknowledge not raised on accept");
    chk_ref_valid: assert property (
        1'b1 |=> refok_q == $past(homed_i))
        else $error("reference valid bit wrong");

    cov_immediate: cover property (accept && ctl_q[CTL_CHANGE_NOW] && state_q != ST_IDLE);
    cov_pend_apply: cover property (state_q == ST_MOVE_PEND ##1 sp_load_o);
    cov_relative: cover property (accept && ctl_q[CTL_RELATIVE]);
    cov_gear_move: cover property (mot_valid_o && sel_q != RST_GEAR_SEL);

endmodule
`default_nettype wire

/* File: hdl/gear_scaler.sv */
`timescale 1ns/100ps
`default_nettype none
module gear_scaler (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Reference increments
    input wire logic ref_valid_i,
    input wire logic signed [15:0] ref_inc_i,
    // Ratio and direction
    input wire logic signed [31:0] num_i,
    input wire logic [31:0] den_i,
    input wire logic [1:0] dir_allow_i,
    // Motor increments
    output logic mot_valid_o,
    output logic signed [31:0] mot_inc_o
);
    import gear_pp_pkg::*;

    logic signed [31:0] rem_q, rem_d;
    logic signed [31:0] inc_q, inc_d;
    logic valid_q, valid_d;
    logic signed [63:0] sum;
    logic signed [63:0] quo;
    logic signed [63:0] rmd;
    logic signed [63:0] den_ext;
    logic allowed;

    always_comb begin
        den_ext = $signed({32'h0000_0000, den_i});
        // Widen before the product: 16384 counts times 131072 overflows 32 bits
        sum = 64'(ref_inc_i) * 64'(num_i) + 64'(rem_q);
        quo = sum / den_ext;
        rmd = sum % den_ext;
        // Negative numerator flips the sign of the product
        allowed = (quo > 0 && dir_allow_i[0]) || (quo < 0 && dir_allow_i[1]);
        rem_d = rem_q;
        inc_d = inc_q;
        valid_d = 1'b0;
        if (ref_valid_i) begin
            rem_d = rmd[31:0];
            if (allowed) begin
                inc_d = quo[31:0];
                valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rem_q <= '0;
            inc_q <= '0;
            valid_q <= 1'b0;
        end else begin
            rem_q <= rem_d;
            inc_q <= inc_d;
            valid_q <= valid_d;
        end
    end

    assign mot_valid_o = valid_q;
    assign mot_inc_o = inc_q;

    chk_dir_block: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        mot_valid_o |-> (mot_inc_o > 0 ? $past(dir_allow_i[0]) : $past(dir_allow_i[1])))
        else $error("gear output moved in a blocked direction");
    chk_rem_bound: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ref_valid_i |=> (rem_q < $signed($past(den_i)) && -rem_q < $signed($past(den_i))))
        else $error("gear remainder exceeds denominator");

endmodule
`default_nettype wire

/* File: include/gear_pp_pkg.sv */
package gear_pp_pkg;

    // Parameter addresses on the drive's parameter channel
    localparam logic [15:0] ADDR_GEAR_DEN = 16'h2606;
    localparam logic [15:0] ADDR_GEAR_NUM = 16'h2608;
    localparam logic [15:0] ADDR_GEAR_DIR = 16'h260A;
    localparam logic [15:0] ADDR_GEAR_SEL = 16'h260C;
    localparam logic [15:0] ADDR_CTL_WORD = 16'h2610;
    localparam logic [15:0] ADDR_STAT_WORD = 16'h2612;
    localparam logic [15:0] ADDR_TGT_POS = 16'h2614;
    localparam logic [15:0] ADDR_TGT_SPD = 16'h2616;
    localparam logic [15:0] ADDR_ACC = 16'h2618;
    localparam logic [15:0] ADDR_DEC = 16'h261A;
    localparam logic [15:0] ADDR_PP_OPT = 16'h261C;

    // Reset values
    localparam logic [31:0] RST_GEAR_NUM = 32'h0000_0001;
    localparam logic [31:0] RST_GEAR_DEN = 32'h0000_0001;
    localparam logic [1:0] RST_GEAR_DIR = 2'h3;
    localparam logic [3:0] RST_GEAR_SEL = 4'h0;
    localparam logic [15:0] RST_CTL_WORD = 16'h0000;
    localparam logic [1:0] RST_PP_OPT = 2'h0;

    // Direction allow codes
    localparam logic [1:0] DIR_POS = 2'h1;
    localparam logic [1:0] DIR_NEG = 2'h2;
    localparam logic [1:0] DIR_BOTH = 2'h3;

    // Relative reference option: 0 previous target, 2 actual position
    localparam logic [1:0] OPT_REL_ACTUAL = 2'h2;

    // Control word bit positions
    localparam int CTL_NEW_SETPOINT = 4;
    localparam int CTL_CHANGE_NOW = 5;
    localparam int CTL_RELATIVE = 6;

    // Status word bit positions
    localparam int STAT_REACHED = 10;
    localparam int STAT_ACK = 12;
    localparam int STAT_ERR = 13;
    localparam int STAT_END = 14;
    localparam int STAT_REF_OK = 15;

    localparam logic [3:0] GEAR_SEL_MAX = 4'hB;
    localparam logic [31:0] MOTOR_RES = 32'h0002_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MOVE = 2'b01,
        ST_MOVE_PEND = 2'b11
    } pp_state_t;

    // Reference counts per motor revolution for fixed selections
    function automatic logic [31:0] ratio_count(input logic [3:0] sel);
        case (sel)
            4'h1: ratio_count = 32'h0000_00C8;
            4'h2: ratio_count = 32'h0000_0190;
            4'h3: ratio_count = 32'h0000_01F4;
            4'h4: ratio_count = 32'h0000_03E8;
            4'h5: ratio_count = 32'h0000_07D0;
            4'h6: ratio_count = 32'h0000_0FA0;
            4'h7: ratio_count = 32'h0000_1388;
            4'h8: ratio_count = 32'h0000_2710;
            4'h9: ratio_count = 32'h0000_1000;
            4'hA: ratio_count = 32'h0000_2000;
            4'hB: ratio_count = 32'h0000_4000;
            default: ratio_count = 32'h0000_0001;
        endcase
    endfunction

endpackage

/* File: verif/param_master.sv */
`timescale 1ns/100ps
`default_nettype none
module param_master (
    // Clock
    input wire logic ref_clk_i,
    // Parameter channel
    output logic par_wr_o,
    output logic par_rd_o,
    output logic [15:0] par_addr_o,
    output logic [31:0] par_wdata_o,
    input wire logic par_ack_i,
    input wire logic [31:0] par_rdata_i
);
    initial begin
        par_wr_o = 1'b0;
        par_rd_o = 1'b0;
        par_addr_o = 16'h0;
        par_wdata_o = 32'h0;
    end

    // Single-cycle strobe: a held write strobe would repeat the write
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic ack);
        @(posedge ref_clk_i);
        par_wr_o <= wr;
        par_rd_o <= !wr;
        par_addr_o <= a;
        par_wdata_o <= d;
        @(posedge ref_clk_i);
        par_wr_o <= 1'b0;
        par_rd_o <= 1'b0;
        // Released bus shows garbage, not the last value
        par_addr_o <= ~a;
        par_wdata_o <= ~d;
        #1;
        q = par_rdata_i;
        ack = par_ack_i;
    endtask
endmodule
`default_nettype wire

/* File: verif/test_gear_pp_setpoint.sv */
`timescale 1ns/100ps
`default_nettype none
module test_gear_pp_setpoint;
    import gear_pp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wr, rd_s, ack, mv, ld, rv = 1'b0, got_mot, got_ld, ack_q;
    logic [15:0] addr, st;
    logic [31:0] wd, rdat, sspd, sacc, sdec, rd_q;
    logic signed [15:0] rinc = 16'h0;
    logic signed [31:0] minc, spos, mot_v, axis = 32'h3E8;
    logic fb = 1'b1, homed = 1'b1, halt = 1'b0, fault = 1'b0, reached = 1'b0;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [15:0] cnt [11] = '{16'hC8, 16'h190, 16'h1F4, 16'h3E8, 16'h7D0, 16'hFA0,
                              16'h1388, 16'h2710, 16'h1000, 16'h2000, 16'h4000};

    param_master i_param_master (.ref_clk_i(ref_clk_i), .par_wr_o(wr), .par_rd_o(rd_s),
        .par_addr_o(addr), .par_wdata_o(wd), .par_ack_i(ack), .par_rdata_i(rdat));
    gear_pp_setpoint i_gear_pp_setpoint (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .par_wr_i(wr), .par_rd_i(rd_s), .par_addr_i(addr), .par_wdata_i(wd),
        .par_ack_o(ack), .par_rdata_o(rdat), .ref_valid_i(rv), .ref_inc_i(rinc),
        .mot_valid_o(mv), .mot_inc_o(minc), .fieldbus_mode_i(fb), .homed_i(homed),
        .halt_i(halt), .fault_i(fault), .standstill_i(1'b1), .axis_pos_i(axis),
        .target_reached_i(reached), .sp_load_o(ld), .sp_pos_o(spos), .sp_speed_o(sspd),
        .sp_acc_o(sacc), .sp_dec_o(sdec), .status_word_o(st));

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic w(input logic [15:0] a, input logic [31:0] d);
        i_param_master.access(1'b1, a, d, rd_q, ack_q);
    endtask

    task automatic r(input logic [15:0] a);
        i_param_master.access(1'b0, a, 32'h0, rd_q, ack_q);
    endtask

    // Pulses last one cycle, so every cycle of the window is sampled
    task automatic watch(input int n);
        got_mot = mv;
        got_ld = ld;
        mot_v = mv ? minc : 32'h0;
        repeat (n) begin
            @(posedge ref_clk_i);
            #1;
            if (mv) begin
                got_mot = 1'b1;
                mot_v = minc;
            end
            if (ld) got_ld = 1'b1;
        end
    endtask

    task automatic step(input logic signed [15:0] inc);
        @(posedge ref_clk_i);
        rv <= 1'b1;
        rinc <= inc;
        @(posedge ref_clk_i);
        rv <= 1'b0;
        rinc <= ~inc;
        #1;
        watch(3);
    endtask

    task automatic reach();
        @(posedge ref_clk_i);
        reached <= 1'b1;
        @(posedge ref_clk_i);
        reached <= 1'b0;
        #1;
        watch(3);
    endtask

    task automatic t_reset();
        r(ADDR_GEAR_NUM);
        check("num", rd_q, 33'h1);
        r(ADDR_GEAR_DEN);
        check("den", rd_q, 33'h1);
        r(ADDR_GEAR_DIR);
        check("dir", rd_q, 33'h3);
        r(ADDR_GEAR_SEL);
        check("sel", rd_q, 33'h0);
        r(16'h2700);
        check("unmapped", rd_q, 33'h0);
        check("ack", ack_q, 33'h1);
        r(ADDR_STAT_WORD);
        check("stat rd", rd_q, 33'hC000);
        w(ADDR_GEAR_SEL, 32'hC);
        r(ADDR_GEAR_SEL);
        check("sel refuse", rd_q, 33'h0);
        w(ADDR_GEAR_DIR, 32'h0);
        r(ADDR_GEAR_DIR);
        check("dir refuse", rd_q, 33'h3);
        step(16'h7);
        check("unity", {got_mot, mot_v}, {1'b1, 32'h7});
        $display("reset test done");
    endtask

    task automatic t_free();
        w(ADDR_GEAR_NUM, 32'h2);
        step(16'h3E8);
        check("x2", {got_mot, mot_v}, {1'b1, 32'h7D0});
        w(ADDR_GEAR_DEN, 32'h4);
        step(16'h3E8);
        check("den pend", {got_mot, mot_v}, {1'b1, 32'h7D0});
        w(ADDR_GEAR_NUM, 32'h2);
        step(16'h3E8);
        check("x1/2", {got_mot, mot_v}, {1'b1, 32'h1F4});
        w(ADDR_GEAR_DEN, 32'h1);
        w(ADDR_GEAR_NUM, 32'hFFFF_FFFF);
        step(16'hA);
        check("reverse", {got_mot, mot_v}, {1'b1, 32'hFFFF_FFF6});
        w(ADDR_GEAR_DIR, 32'h1);
        step(16'hA);
        check("neg blk", {got_mot, mot_v}, 33'h0);
        step(-16'sd10);
        check("pos ok", {got_mot, mot_v}, {1'b1, 32'hA});
        w(ADDR_GEAR_DIR, 32'h2);
        step(-16'sd10);
        check("pos blk", {got_mot, mot_v}, 33'h0);
        w(ADDR_GEAR_DIR, 32'h3);
        w(ADDR_GEAR_DEN, 32'h3);
        w(ADDR_GEAR_NUM, 32'h1);
        step(16'h1);
        step(16'h1);
        check("frac", {got_mot, mot_v}, 33'h0);
        step(16'h1);
        check("carry", {got_mot, mot_v}, {1'b1, 32'h1});
        $display("free gear test done");
    endtask

    task automatic t_fixed();
        for (int i = 0; i < 11; i++) begin
            w(ADDR_GEAR_SEL, 32'(i + 1));
            step(cnt[i]);
            check("one rev", {got_mot, mot_v}, {1'b1, MOTOR_RES});
        end
        w(ADDR_GEAR_SEL, 32'h0);
        $display("fixed gear test done");
    endtask

    task automatic t_profile();
        w(ADDR_TGT_POS, 32'h64);
        w(ADDR_TGT_SPD, 32'h5);
        w(ADDR_ACC, 32'h6);
        w(ADDR_DEC, 32'h7);
        w(ADDR_CTL_WORD, 32'h30);
        watch(4);
        check("load", got_ld, 33'h1);
        check("abs", spos, 33'h64);
        check("acc", sacc, 33'h6);
        check("dec", sdec, 33'h7);
        check("ack", st[STAT_ACK], 33'h1);
        check("ref ok", st[STAT_REF_OK], 33'h1);
        w(ADDR_CTL_WORD, 32'h30);
        watch(4);
        check("level", got_ld, 33'h0);
        w(ADDR_CTL_WORD, 32'h0);
        watch(2);
        check("ack clr", st[STAT_ACK], 33'h0);
        w(ADDR_TGT_POS, 32'hC8);
        w(ADDR_CTL_WORD, 32'h10);
        watch(4);
        check("buffered", got_ld, 33'h0);
        w(ADDR_CTL_WORD, 32'h0);
        w(ADDR_TGT_POS, 32'h12C);
        w(ADDR_TGT_SPD, 32'h9);
        w(ADDR_ACC, 32'hA);
        w(ADDR_DEC, 32'hB);
        w(ADDR_CTL_WORD, 32'h10);
        watch(4);
        check("ack wait", st[STAT_ACK], 33'h1);
        w(ADDR_CTL_WORD, 32'h0);
        reach();
        check("pend load", got_ld, 33'h1);
        check("replaced", {sspd, spos}, {32'h9, 32'h12C});
        check("repl ramps", {sacc[15:0], sdec[15:0]}, 33'h000A_000B);
        check("no reach", st[STAT_REACHED], 33'h0);
        reach();
        check("reached", st[STAT_REACHED], 33'h1);
        check("end", st[STAT_END], 33'h1);
        w(ADDR_TGT_POS, 32'h5);
        w(ADDR_CTL_WORD, 32'h70);
        watch(4);
        check("rel prev", spos, 33'h131);
        w(ADDR_PP_OPT, 32'h2);
        w(ADDR_CTL_WORD, 32'h0);
        w(ADDR_CTL_WORD, 32'h70);
        watch(4);
        check("rel now", {got_ld, spos}, {1'b1, 32'h3ED});
        @(posedge ref_clk_i);
        halt <= 1'b1;
        fault <= 1'b1;
        homed <= 1'b0;
        // Target reached during halt must still read as not reached
        reached <= 1'b1;
        watch(3);
        check("halt", st[STAT_REACHED], 33'h0);
        check("err", st[STAT_ERR], 33'h1);
        check("no ref", st[STAT_REF_OK], 33'h0);
        @(posedge ref_clk_i);
        halt <= 1'b0;
        fault <= 1'b0;
        reached <= 1'b0;
        fb <= 1'b0;
        w(ADDR_CTL_WORD, 32'h0);
        w(ADDR_CTL_WORD, 32'h30);
        watch(4);
        check("local", got_ld, 33'h0);
        $display("profile test done");
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_free();
        t_fixed();
        t_profile();
        final_report();
    end
endmodule
`default_nettype wire
